// File: verilog/swmem_pkg.sv
// Purpose: Shared constants and carriers for the software memory miss block
// Assumes: One core clock; controls arrive as mode selector plus value
// Notes: Line and address widths are fixed
package swmem_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LINES = 8;
  localparam int IDX_W = 3;
  localparam int TAG_W = ADDR_W - IDX_W - 2;

  // =========================================================
  // Mode selectors
  localparam logic [15:0] SEL_SWITCH = 16'h0000;
  localparam logic [15:0] SEL_NOTIFY = 16'h0002;
  localparam logic [15:0] SEL_RUN = 16'h0007;

  // =========================================================
  // Values
  localparam logic [31:0] resource_switch_off = 32'h00000000;
  localparam logic [31:0] resource_switch_on = 32'h00000001;
  localparam logic [31:0] notify_as_event = 32'h00000000;
  localparam logic [31:0] notify_as_interrupt = 32'h00000001;
  localparam logic [31:0] miss_serviced_signal = 32'h00000001;

  // =========================================================
  // Reset values
  localparam logic RST_ENABLED = 1'b0;
  localparam logic RST_IRQ_MODE = 1'b0;

  // Software memory window
  localparam logic [ADDR_W-1:0] SWMEM_BASE = 32'h80000000;
  localparam logic [ADDR_W-1:0] SWMEM_MASK = 32'h80000000;

  localparam int RES_READ = 0;
  localparam int RES_WRITE = 1;

  typedef struct packed {
    logic valid;
    logic res;
    logic [15:0] sel;
    logic [31:0] value;
  } ctrl_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } access_t;

  typedef struct packed {
    logic done;
    logic [DATA_W-1:0] rdata;
  } reply_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } fill_t;

endpackage

// File: verilog/miss_resource.sv
// Purpose: Per-resource mode state and notification for one miss resource
// Assumes: Controls already steered to this resource
// Notes: Notification pulses the cycle after a miss is flagged
module miss_resource (
  input wire logic sysClk,
  input wire logic resetN,
  input wire logic clkEn,
  input wire swmem_pkg::ctrl_t ctrl,
  input wire logic missRaise,
  output logic enabled,
  output logic irqMode,
  output logic pending,
  output logic serviced
);
  logic next_enabled;
  logic next_irqMode;
  logic next_pending;
  logic next_serviced;

  always_comb begin
    next_enabled = enabled;
    next_irqMode = irqMode;
    next_pending = pending;
    next_serviced = 1'b0;
    if (ctrl.valid && ctrl.sel == swmem_pkg::SEL_SWITCH) begin
      if (ctrl.value == swmem_pkg::resource_switch_on) begin
        next_enabled = 1'b1;
      end else if (ctrl.value == swmem_pkg::resource_switch_off) begin
        next_enabled = 1'b0;
      end
    end
    if (ctrl.valid && ctrl.sel == swmem_pkg::SEL_NOTIFY) begin
      if (ctrl.value == swmem_pkg::notify_as_interrupt) begin
        next_irqMode = 1'b1;
      end else if (ctrl.value == swmem_pkg::notify_as_event) begin
        next_irqMode = 1'b0;
      end
    end
    if (ctrl.valid && ctrl.sel == swmem_pkg::SEL_RUN &&
        ctrl.value == swmem_pkg::miss_serviced_signal && pending) begin
      next_pending = 1'b0;
      next_serviced = 1'b1;
    end
    // Raise wins over a same-cycle service
    if (missRaise) begin
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge sysClk or negedge resetN) begin
    if (!resetN) begin
      enabled <= swmem_pkg::RST_ENABLED;
      irqMode <= swmem_pkg::RST_IRQ_MODE;
      pending <= 1'b0;
      serviced <= 1'b0;
    end else if (clkEn) begin
      enabled <= next_enabled;
      irqMode <= next_irqMode;
      pending <= next_pending;
      serviced <= next_serviced;
    end
  end
endmodule

// File: verilog/software_memory_miss_resource.sv
// Purpose: Software memory mini-cache with read and write miss resources
// Assumes: Core issues one access at a time and holds it until done
// Notes: Software fills the line through fillIn before signalling service
// =========================================================
// Overview of operation
// - Each tile has one read miss resource and one separate write miss resource.
// - Selector 0x0000 switches a resource on with value 1 and off with value 0.
// - While on, accesses in the software memory space go to the small cache.
// - While on, a cache miss notifies the read or write resource that matches it.
// - Selector 0x0002 picks events with value 0 and interrupts with value 1.
// - Until changed, a resource notifies by event.
// - Selector 0x0007 with data 1 tells the block that the pending miss is serviced.
module software_memory_miss_resource (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire swmem_pkg::ctrl_t control_set_instruction,
  input wire swmem_pkg::access_t access,
  input wire swmem_pkg::fill_t fillIn,
  output swmem_pkg::reply_t reply,
  output logic [1:0] missEvent,
  output logic [1:0] missIrq,
  output logic [swmem_pkg::ADDR_W-1:0] missAddr,
  output logic bypass
);
  // =========================================================
  // State
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } state_t;

  state_t state;
  state_t next_state;
  logic [swmem_pkg::DATA_W-1:0] lineData [swmem_pkg::LINES];
  logic [swmem_pkg::TAG_W-1:0] lineTag [swmem_pkg::LINES];
  logic [swmem_pkg::LINES-1:0] lineValid;
  logic [swmem_pkg::LINES-1:0] next_lineValid;
  logic [swmem_pkg::ADDR_W-1:0] next_missAddr;
  logic [1:0] next_missEvent;
  logic [1:0] next_missIrq;
  logic next_bypass;
  swmem_pkg::reply_t next_reply;
  swmem_pkg::ctrl_t resCtrl [2];
  logic [1:0] missRaise;
  logic [1:0] enabled;
  logic [1:0] irqMode;
  logic [1:0] pending;
  logic [1:0] serviced;
  logic hit;
  logic inSpace;
  logic curRes;
  logic [swmem_pkg::IDX_W-1:0] idx;
  logic [swmem_pkg::TAG_W-1:0] tag;

  function automatic logic [swmem_pkg::IDX_W-1:0] addrIdx(
    input logic [swmem_pkg::ADDR_W-1:0] a);
    addrIdx = a[swmem_pkg::IDX_W+1:2];
  endfunction

  function automatic logic [swmem_pkg::TAG_W-1:0] addrTag(
    input logic [swmem_pkg::ADDR_W-1:0] a);
    addrTag = a[swmem_pkg::ADDR_W-1:swmem_pkg::IDX_W+2];
  endfunction

  assign idx = addrIdx(access.addr);
  assign tag = addrTag(access.addr);
  assign curRes = access.write;
  assign inSpace = (access.addr & swmem_pkg::SWMEM_MASK) == swmem_pkg::SWMEM_BASE;
  assign hit = lineValid[idx] && lineTag[idx] == tag;

  // =========================================================
  // Two resources, one per access direction
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gRes
      always_comb begin
        resCtrl[g] = control_set_instruction;
        resCtrl[g].valid = control_set_instruction.valid &&
                           control_set_instruction.res == 1'(g);
      end
      miss_resource uRes (
        .sysClk(sys_clk),
        .resetN(reset_n),
        .clkEn(clkEn),
        .ctrl(resCtrl[g]),
        .missRaise(missRaise[g]),
        .enabled(enabled[g]),
        .irqMode(irqMode[g]),
        .pending(pending[g]),
        .serviced(serviced[g])
      );
    end
  endgenerate

  // =========================================================
  // Access sequencing
  always_comb begin
    next_state = state;
    next_lineValid = lineValid;
    next_missAddr = missAddr;
    next_missEvent = 2'b00;
    next_missIrq = 2'b00;
    next_bypass = 1'b0;
    next_reply = '0;
    missRaise = 2'b00;
    case (state)
      ST_IDLE: begin
        if (access.valid) begin
          if (!inSpace || !enabled[curRes]) begin
            // Outside the window or switched off: passes to normal memory
            next_bypass = 1'b1;
            next_state = ST_DONE;
          end else if (hit) begin
            next_reply.done = 1'b1;
            next_reply.rdata = lineData[idx];
            next_state = ST_DONE;
          end else begin
            missRaise[curRes] = 1'b1;
            next_missAddr = access.addr;
            next_missEvent[curRes] = !irqMode[curRes];
            next_missIrq[curRes] = irqMode[curRes];
            next_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (serviced[curRes]) begin
          next_reply.done = 1'b1;
          next_reply.rdata = lineData[idx];
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        // One idle cycle lets the core drop its request
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (fillIn.valid) begin
      next_lineValid[addrIdx(missAddr)] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      lineValid <= '0;
      missAddr <= '0;
      missEvent <= 2'b00;
      missIrq <= 2'b00;
      bypass <= 1'b0;
      reply <= '0;
    end else if (clkEn) begin
      state <= next_state;
      lineValid <= next_lineValid;
      missAddr <= next_missAddr;
      missEvent <= next_missEvent;
      missIrq <= next_missIrq;
      bypass <= next_bypass;
      reply <= next_reply;
    end
  end

  // Line storage needs no reset; valid bits guard it
  // One process owns the array, so a fill and a write hit never race
  always_ff @(posedge sys_clk) begin
    if (clkEn) begin
      // Write hits land in the line so software can see the stored word
      if (state == ST_IDLE && access.valid && access.write && inSpace &&
          enabled[curRes] && hit) begin
        lineData[idx] <= access.wdata;
      end
      // Fill comes last, so it wins on a shared line
      if (fillIn.valid) begin
        lineData[addrIdx(missAddr)] <= fillIn.data;
        lineTag[addrIdx(missAddr)] <= addrTag(missAddr);
      end
    end
  end
endmodule

// File: testbench/swmem_props.sv
// Purpose: Port-level checks for the software memory miss block
// Assumes: Mode and pending state are tracked here from the controls
// Notes: Attached to the top module by bind at the foot of this file
module swmem_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire swmem_pkg::ctrl_t control_set_instruction,
  input wire swmem_pkg::access_t access,
  input wire swmem_pkg::fill_t fillIn,
  input wire swmem_pkg::reply_t reply,
  input wire logic [1:0] missEvent,
  input wire logic [1:0] missIrq,
  input wire logic [swmem_pkg::ADDR_W-1:0] missAddr,
  input wire logic bypass
);
  logic [1:0] en, irq, next_en, next_irq, miss;
  logic pend, pendW, next_pend, next_pendW, serv;
  logic [31:0] fillD, next_fillD;
  swmem_pkg::ctrl_t c;
  assign c = control_set_instruction;
  assign miss = missEvent | missIrq;
  assign serv = clkEn && c.valid && c.sel == swmem_pkg::SEL_RUN && c.res == pendW
    && c.value == swmem_pkg::miss_serviced_signal;
  // =========================================================
  // Shadow state
  always_comb begin
    next_en = en;
    next_irq = irq;
    if (clkEn && c.valid && c.sel == swmem_pkg::SEL_SWITCH) begin
      next_en[c.res] = c.value[0];
    end
    if (clkEn && c.valid && c.sel == swmem_pkg::SEL_NOTIFY) begin
      next_irq[c.res] = c.value[0];
    end
    // Cleared by the service itself; completion follows two edges later
    next_pend = (|miss) || (pend && !serv);
    next_pendW = (|miss) ? miss[1] : pendW;
    next_fillD = fillIn.valid ? fillIn.data : fillD;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      en <= 2'h0;
      irq <= 2'h0;
      pend <= 1'b0;
      pendW <= 1'b0;
      fillD <= 32'h0;
    end else if (clkEn) begin
      en <= next_en;
      irq <= next_irq;
      pend <= next_pend;
      pendW <= next_pendW;
      fillD <= next_fillD;
    end
  end
  // =========================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_serve;
    pend && serv;
  endsequence
  sequence s_raise;
    |miss;
  endsequence
  a_serve_done: assert property (s_serve |-> ##2 reply.done)
    else $error("no completion after service");
  a_hold_pending: assert property (pend && !serv |=> !reply.done)
    else $error("completion without service");
  a_fill_data: assert property (pend && !pendW && serv |-> ##2
    (reply.done && reply.rdata == fillD)) else $error("read miss data differs from fill");
  a_miss_side: assert property (s_raise |-> access.valid
    && miss == (access.write ? 2'h2 : 2'h1)) else $error("miss on wrong resource");
  a_miss_window: assert property (s_raise |-> access.addr[31]
    && missAddr == access.addr && (miss & ~en) == 2'h0) else $error("bad miss cause");
  a_notify_style: assert property ((missIrq & ~irq) == 2'h0
    && (missEvent & irq) == 2'h0) else $error("wrong notification style");
  a_bypass_cause: assert property (bypass |-> !access.addr[31] || !en[access.write])
    else $error("cached access bypassed");
  a_done_pulse: assert property (reply.done |=> !reply.done && !bypass)
    else $error("completion longer than a cycle");
  a_miss_quiet: assert property (s_raise |-> !reply.done && !bypass)
    else $error("miss completed at once");
endmodule
bind software_memory_miss_resource swmem_props chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .clkEn(clkEn), .control_set_instruction(control_set_instruction), .access(access),
  .fillIn(fillIn), .reply(reply), .missEvent(missEvent), .missIrq(missIrq),
  .missAddr(missAddr), .bypass(bypass));

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the software memory miss block
// Assumes: Inputs change on the falling clock edge
// Notes: Fill data is the inverted address, so hits can be predicted
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic res;
    logic [15:0] sel;
    logic [31:0] val;
    logic wr;
    logic [31:0] addr;
    logic [1:0] ev;
    logic [1:0] iq;
    logic byp;
  } row_t;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  swmem_pkg::ctrl_t ctrlIn = '0;
  swmem_pkg::access_t accIn = '0;
  swmem_pkg::fill_t fillIn = '0;
  swmem_pkg::reply_t reply;
  logic [1:0] missEvent;
  logic [1:0] missIrq;
  logic [31:0] missAddr;
  logic bypass;
  int err_total = 0;
  int check_count = 0;
  row_t rows [8] = '{
    '{1'b0, 16'h0005, 32'h1, 1'b0, 32'h80000004, 2'h0, 2'h0, 1'b1},
    '{1'b0, 16'h0000, 32'h1, 1'b0, 32'h80000004, 2'h1, 2'h0, 1'b0},
    '{1'b0, 16'h0005, 32'h1, 1'b0, 32'h80000004, 2'h0, 2'h0, 1'b0},
    '{1'b0, 16'h0005, 32'h1, 1'b0, 32'h00000004, 2'h0, 2'h0, 1'b1},
    '{1'b1, 16'h0000, 32'h1, 1'b1, 32'h80000010, 2'h2, 2'h0, 1'b0},
    '{1'b0, 16'h0002, 32'h1, 1'b0, 32'h8000000C, 2'h0, 2'h1, 1'b0},
    '{1'b0, 16'h0002, 32'h0, 1'b0, 32'h80000008, 2'h1, 2'h0, 1'b0},
    '{1'b0, 16'h0000, 32'h0, 1'b0, 32'h80000004, 2'h0, 2'h0, 1'b1}};
  always #4 sys_clk = ~sys_clk;
  software_memory_miss_resource uut (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
    .control_set_instruction(ctrlIn), .access(accIn), .fillIn(fillIn), .reply(reply),
    .missEvent(missEvent), .missIrq(missIrq), .missAddr(missAddr), .bypass(bypass));
  // =========================================================
  // Compare and report
  task automatic chkW(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkB(input logic got, input logic exp);
    chkW({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // =========================================================
  // Drivers
  task automatic send(input logic r, input logic [15:0] s, input logic [31:0] v);
    ctrlIn = '{1'b1, r, s, v};
    @(negedge sys_clk);
    ctrlIn.valid = 1'b0;
  endtask
  // Bad first services the other resource, which must not complete
  task automatic run(input row_t w, input logic bad);
    logic hit;
    hit = !w.byp && w.ev == 2'h0 && w.iq == 2'h0;
    accIn = '{1'b1, w.wr, w.addr, ~w.addr};
    @(negedge sys_clk);
    chkB(bypass, w.byp);
    chkW(32'(missEvent), 32'(w.ev));
    chkW(32'(missIrq), 32'(w.iq));
    chkB(reply.done, hit);
    if (hit) chkW(reply.rdata, ~w.addr);
    if (!hit && !w.byp) begin
      chkW(missAddr, w.addr);
      fillIn = '{1'b1, ~w.addr};
      @(negedge sys_clk);
      fillIn.valid = 1'b0;
      if (bad) begin
        send(!w.wr, swmem_pkg::SEL_RUN, swmem_pkg::miss_serviced_signal);
        @(negedge sys_clk);
        chkB(reply.done, 1'b0);
      end
      send(w.wr, swmem_pkg::SEL_RUN, swmem_pkg::miss_serviced_signal);
      chkB(reply.done, 1'b0);
      // Service registers in the resource first, so completion lags a cycle
      @(negedge sys_clk);
      chkB(reply.done, 1'b1);
      if (!w.wr) chkW(reply.rdata, ~w.addr);
    end
    accIn.valid = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  // =========================================================
  // Sequence
  initial begin
    repeat (4) @(negedge sys_clk);
    chkB(reply.done | bypass | (|missEvent) | (|missIrq), 1'b0);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chkB(reply.done | bypass | (|missEvent) | (|missIrq), 1'b0);
    foreach (rows[i]) begin
      send(rows[i].res, rows[i].sel, rows[i].val);
      run(rows[i], 1'b0);
    end
    run(row_t'{1'b0, 16'h0, 32'h0, 1'b1, 32'h80000014, 2'h2, 2'h0, 1'b0}, 1'b1);
    // Frozen clock enable must drop the switch-on
    clkEn = 1'b0;
    send(1'b0, swmem_pkg::SEL_SWITCH, swmem_pkg::resource_switch_on);
    clkEn = 1'b1;
    run(row_t'{1'b0, 16'h0, 32'h0, 1'b0, 32'h80000004, 2'h0, 2'h0, 1'b1}, 1'b0);
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    err_total++;
    tally_and_finish();
  end
endmodule
